// File: verilog/ufs_pkg.sv
package ufs_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [31:0] UFS_A_MODE    = 32'h5000_1170; // Queue test access mode
	localparam logic [31:0] UFS_A_FLAGS   = 32'h5000_117C; // Status flags
	localparam logic [31:0] UFS_A_TXLVL   = 32'h5000_1180; // Transmit level
	localparam logic [31:0] UFS_A_RXLVL   = 32'h5000_1184; // Receive level
	localparam logic [31:0] UFS_A_FLUSH   = 32'h5000_1188; // Self-clearing flush bits
	localparam logic [31:0] UFS_A_IRQ_ST  = 32'h5000_11A0; // Sticky event status
	localparam logic [31:0] UFS_A_IRQ_MSK = 32'h5000_11A4; // Event mask

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int UFS_B_RFF   = 4; // Receive queue full
	localparam int UFS_B_RFNE  = 3; // Receive queue not empty
	localparam int UFS_B_TFE   = 2; // Transmit queue empty
	localparam int UFS_B_TFNF  = 1; // Transmit queue has space
	localparam int UFS_B_BUSY  = 0; // Serial activity
	localparam int UFS_B_FL_TX = 2; // Transmit flush bit
	localparam int UFS_B_FL_RX = 1; // Receive flush bit
	localparam int UFS_B_MODE  = 0; // Test access mode bit
	localparam int UFS_I_RXFULL  = 0; // Event: receive queue became full
	localparam int UFS_I_TXEMPTY = 1; // Event: transmit queue became empty
	localparam int UFS_I_IDLE    = 2; // Event: busy fell
	localparam int UFS_NIRQ      = 3; // Number of events
	localparam logic [15:0] UFS_FLAGS_RST = 16'h0006; // Flags after reset
	localparam logic [15:0] UFS_LVL_RST   = 16'h0000; // Levels after reset

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		UFS_IDLE = 2'b01,
		UFS_ACK  = 2'b10
	} ufs_bus_e;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [31:0] address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} ufs_avm_req_s;

	// Queue activity reported by the datapath
	typedef struct packed {
		logic tx_push;      // Entry written to transmit queue
		logic tx_pop;       // Entry taken by transmitter
		logic rx_push;      // Entry written by receiver
		logic rx_pop;       // Entry read by software
		logic tx_shifting;  // Character on the line
		logic rx_receiving; // Start bit accepted at mid-bit
	} ufs_fifo_ev_s;

	// Whole state of the block
	typedef struct packed {
		ufs_bus_e              st;
		logic                  waitreq;
		logic [31:0]           rdata;
		logic [15:0]           tx_cnt;
		logic [15:0]           rx_cnt;
		logic                  mode;
		logic [7:0]            dly;
		logic                  busy;
		logic [UFS_NIRQ-1:0]   irq_st;
		logic [UFS_NIRQ-1:0]   irq_msk;
		logic                  irq;
		logic                  rst_tx;
		logic                  rst_rx;
	} ufs_state_s;

endpackage : ufs_pkg

// File: verilog/ufs_status.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps

// Functional notes
// - Receive full flag bit4 while all occupied
// - Receive not-empty flag bit3 when entries held
// - Transmit empty flag bit2, one after reset
// - Transmit has-space flag bit1, one after reset
// - Busy flag bit0 during serial transfer
// - Busy may miss start bit before mid-bit
// - BUSY_DLY+1 cycles of the block clock delay busy assertion
// - Transmit level count in bits 15:0
// - Receive level count in bits 15:0
// - Test mode change empties both queues
// - Transmit flush bit empties transmit queue
module ufs_status #(
	parameter int DEPTH    = 16, // Queue depth
	parameter int BUSY_DLY = 0   // Clock cycles of busy delay, 0 for one clock
) (
	// Clock and reset
	input  logic                  clk,
	input  logic                  srst,
	// Avalon-MM slave
	input  ufs_pkg::ufs_avm_req_s avm_req,
	output logic [31:0]           avm_readdata,
	output logic                  avm_waitrequest,
	// Queue activity
	input  ufs_pkg::ufs_fifo_ev_s fifo_ev,
	// Queue control
	output logic                  tx_fifo_reset,
	output logic                  rx_fifo_reset,
	output logic                  queue_test_access_mode,
	// Interrupt
	output logic                  irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Depth at field width
	localparam logic [15:0] DEPTH_W = 16'(DEPTH);
	// Busy delay at counter width
	localparam logic [7:0]  DLY_W   = 8'(BUSY_DLY);

	// Next level of one queue
	function automatic logic [15:0] ufs_count(
		input logic [15:0] c,
		input logic        push,
		input logic        pop,
		input logic        clr
	);
		logic up;
		logic dn;
		up = push && (c != DEPTH_W);
		dn = pop && (c != 16'h0000);
		if (clr)
			return 16'h0000;
		else if (up && !dn)
			return 16'(c + 16'h0001);
		else if (dn && !up)
			return 16'(c - 16'h0001);
		else
			return c;
	endfunction : ufs_count

	// Status flag word from levels and busy
	function automatic logic [15:0] ufs_flags(
		input logic [15:0] tx,
		input logic [15:0] rx,
		input logic        bsy
	);
		logic [15:0] f;
		f                   = 16'h0000;           // Reserved bits read zero
		f[ufs_pkg::UFS_B_RFF]  = (rx == DEPTH_W);
		f[ufs_pkg::UFS_B_RFNE] = (rx != 16'h0000);
		f[ufs_pkg::UFS_B_TFE]  = (tx == 16'h0000);
		f[ufs_pkg::UFS_B_TFNF] = (tx != DEPTH_W);
		f[ufs_pkg::UFS_B_BUSY] = bsy;
		return f;
	endfunction : ufs_flags

	// ----------------------------------------
	// State
	// ----------------------------------------
	ufs_pkg::ufs_state_s q;                // Registered state
	ufs_pkg::ufs_state_s d;                // Next state
	logic                req;              // Request present
	logic                wr_acc;           // Write taken this edge
	logic [15:0]         flags_q;          // Flags from present state
	logic                busy_raw;         // Undelayed activity

	assign req     = avm_req.read || avm_req.write;
	assign wr_acc  = (q.st == ufs_pkg::UFS_ACK) && avm_req.write;
	assign flags_q = ufs_flags(q.tx_cnt, q.rx_cnt, q.busy);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------

	// Bus slave, queue levels, busy and events
	always_comb
	begin
		logic                         mode_chg;
		logic                         clr_tx;
		logic                         clr_rx;
		logic [ufs_pkg::UFS_NIRQ-1:0] wclr;
		logic [ufs_pkg::UFS_NIRQ-1:0] ev;
		logic [15:0]                  f_new;
		mode_chg = 1'b0;
		clr_tx   = 1'b0;
		clr_rx   = 1'b0;
		wclr     = '0;
		ev       = '0;
		f_new    = 16'h0000;
		d        = q;
		d.waitreq = 1'b1;
		d.rst_tx  = 1'b0;
		d.rst_rx  = 1'b0;

		// Bus handshake: one wait cycle, then answer
		case (q.st)
			ufs_pkg::UFS_IDLE:
			begin
				// Take a new request and prepare the answer
				if (req)
				begin
					d.st      = ufs_pkg::UFS_ACK;
					d.waitreq = 1'b0;
					if (avm_req.read)
					begin
						case (avm_req.address)
							ufs_pkg::UFS_A_MODE:    d.rdata = {31'h0000_0000, q.mode};
							ufs_pkg::UFS_A_FLAGS:   d.rdata = {16'h0000, flags_q};
							ufs_pkg::UFS_A_TXLVL:   d.rdata = {16'h0000, q.tx_cnt};
							ufs_pkg::UFS_A_RXLVL:   d.rdata = {16'h0000, q.rx_cnt};
							ufs_pkg::UFS_A_IRQ_ST:  d.rdata = {29'h0000_0000, q.irq_st};
							ufs_pkg::UFS_A_IRQ_MSK: d.rdata = {29'h0000_0000, q.irq_msk};
							default:                d.rdata = 32'h0000_0000;
						endcase
					end
				end
			end
			ufs_pkg::UFS_ACK:
			begin
				// Write takes effect at the edge that sees waitrequest low
				d.st = ufs_pkg::UFS_IDLE;
				if (wr_acc)
				begin
					case (avm_req.address)
						ufs_pkg::UFS_A_MODE:
						begin
							d.mode   = avm_req.writedata[ufs_pkg::UFS_B_MODE];
							mode_chg = d.mode != q.mode;
						end
						ufs_pkg::UFS_A_FLUSH:
						begin
							clr_tx = avm_req.writedata[ufs_pkg::UFS_B_FL_TX];
							clr_rx = avm_req.writedata[ufs_pkg::UFS_B_FL_RX];
						end
						ufs_pkg::UFS_A_IRQ_ST:  wclr      = avm_req.writedata[ufs_pkg::UFS_NIRQ-1:0];
						ufs_pkg::UFS_A_IRQ_MSK: d.irq_msk = avm_req.writedata[ufs_pkg::UFS_NIRQ-1:0];
						// Flags, levels and unmapped words take no write
						default: ;
					endcase
				end
			end
			default:
			begin
				d.st = ufs_pkg::UFS_IDLE;
			end
		endcase

		// A mode change empties both queues
		clr_tx = clr_tx || mode_chg;
		clr_rx = clr_rx || mode_chg;
		d.rst_tx = clr_tx;
		d.rst_rx = clr_rx;

		// Queue levels follow pushes and pops
		d.tx_cnt = ufs_count(q.tx_cnt, fifo_ev.tx_push, fifo_ev.tx_pop, clr_tx);
		d.rx_cnt = ufs_count(q.rx_cnt, fifo_ev.rx_push, fifo_ev.rx_pop, clr_rx);

		// Busy waits for BUSY_DLY+1 cycles of steady activity
		if (!busy_raw)
		begin
			d.dly  = 8'h00;
			d.busy = 1'b0;
		end
		else if (q.dly >= DLY_W)
		begin
			d.busy = 1'b1;
		end
		else
		begin
			d.dly = 8'(q.dly + 8'h01);
		end

		// Events from flag edges; a set beats a clear in the same cycle
		f_new = ufs_flags(d.tx_cnt, d.rx_cnt, d.busy);
		ev[ufs_pkg::UFS_I_RXFULL]  = f_new[ufs_pkg::UFS_B_RFF] && !flags_q[ufs_pkg::UFS_B_RFF];
		ev[ufs_pkg::UFS_I_TXEMPTY] = f_new[ufs_pkg::UFS_B_TFE] && !flags_q[ufs_pkg::UFS_B_TFE];
		ev[ufs_pkg::UFS_I_IDLE]    = q.busy && !d.busy;
		d.irq_st = (q.irq_st & ~wclr) | ev;
		d.irq    = |(d.irq_st & d.irq_msk);
	end

	// Activity: data held or a character on the line
	assign busy_raw = (q.tx_cnt != 16'h0000) || (q.rx_cnt != 16'h0000)
		|| fifo_ev.tx_shifting || fifo_ev.rx_receiving;

	// ----------------------------------------
	// State register
	// ----------------------------------------

	// Synchronous reset to documented values
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			q         <= '0;
			q.st      <= ufs_pkg::UFS_IDLE;
			q.waitreq <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avm_readdata           = q.rdata;
	assign avm_waitrequest        = q.waitreq;
	assign tx_fifo_reset          = q.rst_tx;
	assign rx_fifo_reset          = q.rst_rx;
	assign queue_test_access_mode = q.mode;
	assign irq                    = q.irq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Status read reports receive full from the level
	a_rx_full_read: assert property (
		(q.st == ufs_pkg::UFS_IDLE) && avm_req.read && avm_req.address == ufs_pkg::UFS_A_FLAGS
		|=> avm_readdata[ufs_pkg::UFS_B_RFF] == ($past(q.rx_cnt) == DEPTH_W) && !avm_waitrequest)
		else $error("receive full flag wrong");

	// Status read reports receive not empty
	a_rx_ne_read: assert property (
		(q.st == ufs_pkg::UFS_IDLE) && avm_req.read && avm_req.address == ufs_pkg::UFS_A_FLAGS
		|=> avm_readdata[ufs_pkg::UFS_B_RFNE] == ($past(q.rx_cnt) != 16'h0000))
		else $error("receive not empty flag wrong");

	// Transmit empty follows a push within one cycle
	a_tx_empty_clr: assert property (
		q.tx_cnt == 16'h0000 && fifo_ev.tx_push && !tx_fifo_reset && !$past(srst)
		|=> !flags_q[ufs_pkg::UFS_B_TFE] || q.rst_tx)
		else $error("transmit empty flag not cleared");

	// A push into a full transmit queue is dropped and has-space stays low
	a_tx_space: assert property (
		q.tx_cnt == DEPTH_W && fifo_ev.tx_push && !fifo_ev.tx_pop
		|=> (q.tx_cnt == DEPTH_W && !flags_q[ufs_pkg::UFS_B_TFNF]) || q.rst_tx)
		else $error("transmit space flag wrong");

	// Busy drops one cycle after activity ends
	a_busy_fall: assert property (
		!busy_raw |=> !q.busy && q.dly == 8'h00)
		else $error("busy did not fall");

	// Busy rises only after the programmed delay of steady activity
	a_busy_delay: assert property (
		$rose(q.busy) |-> $past(q.dly) == DLY_W && $past(busy_raw))
		else $error("busy rose without delay");

	// Transmit level read returns the count with zero upper half
	a_lvl_read: assert property (
		(q.st == ufs_pkg::UFS_IDLE) && avm_req.read && avm_req.address == ufs_pkg::UFS_A_TXLVL
		|=> avm_readdata == {16'h0000, $past(q.tx_cnt)})
		else $error("transmit level read wrong");

	// Mode change leaves both queues empty
	a_mode_empty: assert property (
		$changed(q.mode) |-> q.tx_cnt == 16'h0000 && q.rx_cnt == 16'h0000 && q.rst_tx && q.rst_rx)
		else $error("mode change did not empty queues");

	// Transmit flush empties the transmit level
	a_tx_flush: assert property (
		wr_acc && avm_req.address == ufs_pkg::UFS_A_FLUSH && avm_req.writedata[ufs_pkg::UFS_B_FL_TX]
		|=> q.tx_cnt == 16'h0000 && tx_fifo_reset ##1 !tx_fifo_reset)
		else $error("transmit flush failed");

	// Write to a status word leaves mask and mode unchanged
	a_ro_write: assert property (
		wr_acc && avm_req.address == ufs_pkg::UFS_A_FLAGS |=> $stable(q.mode) && $stable(q.irq_msk))
		else $error("read-only write had effect");

	// Every taken request gets exactly one answer cycle
	a_wait_one: assert property (
		(q.st == ufs_pkg::UFS_IDLE) && req |=> !avm_waitrequest ##1 avm_waitrequest)
		else $error("answer cycle count wrong");

	// Receive flush empties the receive level and pulses its reset
	a_rx_flush: assert property (
		wr_acc && avm_req.address == ufs_pkg::UFS_A_FLUSH && avm_req.writedata[ufs_pkg::UFS_B_FL_RX] |=> q.rx_cnt == 16'h0000 && rx_fifo_reset)
		else $error("receive flush failed");

	// A character arriving at a full receive queue is lost, level stays full
	a_rx_full_hold: assert property (
		q.rx_cnt == DEPTH_W && fifo_ev.rx_push && !fifo_ev.rx_pop |=> q.rx_cnt == DEPTH_W || q.rst_rx)
		else $error("receive full level changed");

	// A read from an empty receive queue leaves the level at zero
	a_rx_empty_pop: assert property (
		q.rx_cnt == 16'h0000 && fifo_ev.rx_pop && !fifo_ev.rx_push |=> q.rx_cnt == 16'h0000)
		else $error("receive level underflow");

	// A push into a transmit queue with space raises the level by one
	a_tx_push_count: assert property (
		q.tx_cnt < DEPTH_W && fifo_ev.tx_push && !fifo_ev.tx_pop |=> q.tx_cnt == $past(q.tx_cnt) + 16'h0001 || q.rst_tx)
		else $error("transmit level did not count up");

	// Levels never pass the queue depth
	a_level_bound: assert property (
		q.tx_cnt <= DEPTH_W && q.rx_cnt <= DEPTH_W)
		else $error("queue level above depth");

	// Interrupt output follows unmasked status
	a_irq_level: assert property (
		irq == |(q.irq_st & q.irq_msk))
		else $error("interrupt level wrong");

	// Receive full event stays until software clears it
	a_event_sticky: assert property (
		q.irq_st[ufs_pkg::UFS_I_RXFULL] && !wr_acc |=> q.irq_st[ufs_pkg::UFS_I_RXFULL])
		else $error("event status not sticky");

	// Busy falling always records the idle event
	a_idle_event: assert property (
		q.busy && !busy_raw |=> q.irq_st[ufs_pkg::UFS_I_IDLE])
		else $error("idle event not recorded");

endmodule : ufs_status

// File: bench/ufs_partner.sv
`timescale 1ns/1ps

// Remote serial device: sends characters in and drains the transmit queue
module ufs_partner (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Commands from the bench, slow sets the character time
	input  wire logic       send_go,
	input  wire logic       take_go,
	input  wire logic [3:0] slow,
	// Line-side activity
	output logic            rx_receiving,
	output logic            rx_push,
	output logic            tx_shifting,
	output logic            tx_pop
);
	logic [3:0] rx_t_q; // Receive cycles left
	logic [3:0] tx_t_q; // Shift cycles left

	// Start bit runs slow+1 cycles, then the character lands
	always_ff @(posedge clk)
	begin
		rx_push <= 1'b0;
		tx_pop  <= take_go & ~srst;
		if (srst)
		begin
			rx_t_q <= '0;
			tx_t_q <= '0;
		end
		else
		begin
			if (send_go)
				rx_t_q <= slow + 4'h1;
			else if (rx_t_q != 4'h0)
			begin
				rx_t_q  <= rx_t_q - 4'h1;
				rx_push <= (rx_t_q == 4'h1);
			end
			if (take_go)
				tx_t_q <= slow + 4'h1;
			else if (tx_t_q != 4'h0)
				tx_t_q <= tx_t_q - 4'h1;
		end
	end

	assign rx_receiving = (rx_t_q != 4'h0);
	assign tx_shifting  = (tx_t_q != 4'h0);
endmodule : ufs_partner

// File: bench/ufs_status_tb.sv
`timescale 1ns/1ps

module ufs_status_tb;
	localparam int          DEPTH = 16;
	localparam logic [31:0] AF    = ufs_pkg::UFS_A_FLAGS;
	localparam logic [31:0] AT    = ufs_pkg::UFS_A_TXLVL;
	localparam logic [31:0] AR    = ufs_pkg::UFS_A_RXLVL;
	logic                  clk;
	logic                  srst;
	ufs_pkg::ufs_avm_req_s req;
	ufs_pkg::ufs_fifo_ev_s ev;
	logic [31:0]           rdata;
	logic                  wreq;
	logic                  irq;
	logic                  txr, rxr, tmode;
	int                    ntx = 0, nrx = 0;
	logic                  tx_push, tx_pop, rx_push, rx_pop, tx_sh, rx_rc;
	logic                  send_go, take_go;
	logic [3:0]            slow;
	logic [31:0]           d;
	int                    bad_count, checked, k, i;

	assign ev = {tx_push, tx_pop, rx_push, rx_pop, tx_sh, rx_rc};

	ufs_status #(.DEPTH(DEPTH), .BUSY_DLY(3)) dut (.clk(clk), .srst(srst), .avm_req(req),
		.avm_readdata(rdata), .avm_waitrequest(wreq), .fifo_ev(ev), .tx_fifo_reset(txr),
		.rx_fifo_reset(rxr), .queue_test_access_mode(tmode), .irq(irq));

	ufs_partner far (.clk(clk), .srst(srst), .send_go(send_go), .take_go(take_go), .slow(slow),
		.rx_receiving(rx_rc), .rx_push(rx_push), .tx_shifting(tx_sh), .tx_pop(tx_pop));

	// Clock, 4 ns period
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Count queue control reset pulses
	always @(posedge clk)
	begin
		if (!srst)
		begin
			ntx <= ntx + int'(txr);
			nrx <= nrx + int'(rxr);
		end
	end

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		req <= '{address: a, read: ~wr, write: wr, writedata: wd};
		@(posedge clk);
		while (wreq !== 1'b0)
			@(posedge clk);
		rd = rdata;
		req <= '0;
		@(posedge clk);
	endtask : bus

	task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, '0, d);
		chk(nm, exp, d);
	endtask : rd

	// Expected flag word from the two levels and activity
	function automatic logic [31:0] f(input int tx, input int rx, input logic b);
		return {27'h0, rx == DEPTH, rx != 0, tx == 0, tx != DEPTH, b};
	endfunction : f

	// Pushes or pops held high for n edges, one entry each
	task automatic pulse(input bit tx, input int n);
		if (tx) tx_push <= 1'b1; else rx_pop <= 1'b1;
		repeat (n) @(posedge clk);
		tx_push <= 1'b0;
		rx_pop  <= 1'b0;
		@(posedge clk);
	endtask : pulse

	// Remote sends one character at a given pace
	task automatic send(input logic [3:0] s);
		slow    <= s;
		send_go <= 1'b1;
		@(posedge clk);
		send_go <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : send

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// Watchdog
	initial
	begin
		#80000;
		bad_count++;
		tally_and_finish();
	end

	// Main sequence
	initial
	begin
		void'($urandom(21));
		{srst, tx_push, rx_pop, send_go, take_go} = 5'b10000;
		req = '0;
		slow = 4'h0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd("flags", AF, 32'h0000_0006);
		rd("tx level", AT, '0);
		rd("rx level", AR, '0);
		$display("reset test done");
		k = $urandom_range(1, DEPTH - 1);
		pulse(1'b1, k);
		rd("tx level", AT, 32'(k));
		rd("flags", AF, f(k, 0, 1'b1));
		pulse(1'b1, DEPTH - k + 1);
		rd("flags", AF, f(DEPTH, 0, 1'b1));
		bus(1'b1, AF, 32'hFFFF_FFFF, d);
		bus(1'b1, AT, 32'h0000_0000, d);
		rd("tx level", AT, 32'(DEPTH));
		rd("unmapped", 32'h5000_1190, '0);
		bus(1'b1, ufs_pkg::UFS_A_FLUSH, 32'h0000_0006, d);
		rd("tx level", AT, '0);
		rd("flags", AF, f(0, 0, 1'b0));
		$display("transmit test done");
		bus(1'b1, ufs_pkg::UFS_A_IRQ_MSK, 32'h0000_0001, d);
		for (i = 0; i <= DEPTH; i++)
		begin
			send(4'($urandom_range(0, 7)));
			repeat (10) @(posedge clk);
		end
		rd("rx level", AR, 32'(DEPTH));
		rd("flags", AF, f(0, DEPTH, 1'b1));
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, ufs_pkg::UFS_A_IRQ_MSK, '0, d);
		@(posedge clk);
		chk("irq masked", '0, {31'h0, irq});
		bus(1'b1, ufs_pkg::UFS_A_IRQ_ST, 32'h0000_0001, d);
		bus(1'b1, ufs_pkg::UFS_A_IRQ_MSK, 32'h0000_0001, d);
		@(posedge clk);
		chk("irq cleared", '0, {31'h0, irq});
		pulse(1'b0, 1);
		rd("flags", AF, f(0, DEPTH - 1, 1'b1));
		pulse(1'b0, DEPTH);
		rd("flags", AF, f(0, 0, 1'b0));
		$display("receive test done");
		pulse(1'b1, 1);
		slow    <= 4'hE;
		take_go <= 1'b1;
		@(posedge clk);
		take_go <= 1'b0;
		repeat (4) @(posedge clk);
		rd("flags", AF, f(0, 0, 1'b1));
		repeat (20) @(posedge clk);
		rd("flags", AF, f(0, 0, 1'b0));
		send(4'hE);
		rd("flags", AF, f(0, 0, 1'b0));
		repeat (20) @(posedge clk);
		rd("flags", AF, f(0, 1, 1'b1));
		$display("busy test done");
		bus(1'b1, ufs_pkg::UFS_A_MODE, 32'h0000_0001, d);
		rd("rx level", AR, '0);
		rd("flags", AF, f(0, 0, 1'b0));
		rd("mode", ufs_pkg::UFS_A_MODE, 32'h0000_0001);
		chk("mode pin", 32'h0000_0001, {31'h0, tmode});
		bus(1'b1, ufs_pkg::UFS_A_MODE, '0, d);
		@(posedge clk);
		chk("tx resets", 32'h0000_0003, ntx);
		chk("rx resets", 32'h0000_0003, nrx);
		$display("mode test done");
		tally_and_finish();
	end
endmodule : ufs_status_tb
